// File: core/board_mux_end.sv
// main-board end of the modem-control line multiplexer
`include "tdm_map.svh"

// Summary of operation
// - board drives continuous 10 MHz bit clock
// - sixteen one-bit slots repeat without gaps
// - sync low for one bit, from mid slot 15 to mid slot 0
// - module aligns: slot after sync is 0
// - board drives outgoing data, only samples incoming
// - module drives incoming data in same framing
// - outgoing slots: port controls, ident request
// - incoming slots: port status and ident bits
// - sync changes on bit clock falling edge
// - outgoing data changes on rising edge
// - incoming bits captured on rising edge
// - module launches data on rising edge
// - pure hardware, no software registers
module board_mux_end
  import tdm_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = `TDM_HALF_CYCLES
)
(
  // system
  input  wire logic clk,
  input  wire logic srst,
  // link
  tdm_link_if.board link,
  // controls from the serial controllers
  input  wire logic port3_rts,
  input  wire logic port3_dtr,
  input  wire logic port3_local_loop_or_module_select,
  input  wire logic port3_remote_loop,
  input  wire logic port4_rts,
  input  wire logic port4_dtr,
  input  wire logic port4_local_loop,
  input  wire logic port4_remote_loop,
  input  wire logic module_ident_request,
  // status toward the serial controllers
  output logic      port3_cts,
  output logic      port3_set_ready_or_ident_bit1,
  output logic      port3_dcd,
  output logic      port3_test_mode_or_ident_bit0,
  output logic      port3_ring,
  output logic      port4_cts,
  output logic      port4_set_ready_or_ident_bit3,
  output logic      port4_dcd,
  output logic      port4_test_mode_or_ident_bit2,
  output logic      port4_ring
);

  // ----------------------------------------------------------------------
  // bit clock divider
  // ----------------------------------------------------------------------
  // the board owns the link clock, so it is derived here and the
  // rise and fall moments are known without sampling the pin back
  logic [`TDM_DIV_W-1:0] div_q;
  logic [`TDM_DIV_W-1:0] div_d;
  logic                  bclk_q;
  logic                  bclk_d;
  logic                  div_done;
  logic                  rise_evt;
  logic                  fall_evt;

  assign div_done = (div_q == `TDM_DIV_W'(HALF_CYCLES - 1));
  assign div_d    = div_done ? '0 : `TDM_DIV_W'(div_q + 1'h1);
  assign bclk_d   = div_done ? ~bclk_q : bclk_q;
  assign rise_evt = div_done & ~bclk_q;
  assign fall_evt = div_done & bclk_q;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      div_q  <= '0;
      bclk_q <= 1'h0;
    end
    else
    begin
      div_q  <= div_d;
      bclk_q <= bclk_d;
    end
  end

  // ----------------------------------------------------------------------
  // slot counter
  // ----------------------------------------------------------------------
  // reset value is the last slot so the first rising edge opens slot 0
  slot_t slot_q;
  slot_t slot_d;

  assign slot_d = slot_t'(slot_q + 4'h1);

  always_ff @(posedge clk)
  begin
    if (srst)
      slot_q <= `TDM_SLOT_RESET;
    else if (rise_evt)
      slot_q <= slot_d;
  end

  // ----------------------------------------------------------------------
  // frame sync
  // ----------------------------------------------------------------------
  // low from the falling edge inside slot 15 to the one inside slot 0,
  // so it is steady at the rising edge that closes slot 15
  logic sync_n_q;
  logic sync_n_d;

  assign sync_n_d = (slot_q == `TDM_SLOT_LAST) ? 1'h0 : 1'h1;

  always_ff @(posedge clk)
  begin
    if (srst)
      sync_n_q <= `TDM_SYNC_IDLE;
    else if (fall_evt)
      sync_n_q <= sync_n_d;
  end

  // ----------------------------------------------------------------------
  // outgoing data
  // ----------------------------------------------------------------------
  logic [`TDM_SLOTS-1:0] tx_slots;
  logic                  dout_q;

  assign tx_slots[`SLOT_P3_RTS]        = port3_rts;
  assign tx_slots[`SLOT_P3_DTR]        = port3_dtr;
  assign tx_slots[`SLOT_P3_LLB_MODSEL] = port3_local_loop_or_module_select;
  assign tx_slots[`SLOT_P3_RLB]        = port3_remote_loop;
  assign tx_slots[`SLOT_P4_RTS]        = port4_rts;
  assign tx_slots[`SLOT_P4_DTR]        = port4_dtr;
  assign tx_slots[`SLOT_P4_LLB]        = port4_local_loop;
  assign tx_slots[`SLOT_P4_RLB]        = port4_remote_loop;
  assign tx_slots[`SLOT_IDENT_REQ]     = module_ident_request;

  genvar g;
  generate
    for (g = `TDM_TX_USED; g < `TDM_SLOTS; g++)
    begin : g_tx_rsvd
      assign tx_slots[g] = `TDM_RESERVED_LEVEL;
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (srst)
      dout_q <= `TDM_DATA_IDLE;
    else if (rise_evt)
      dout_q <= tx_slots[slot_d];
  end

  // ----------------------------------------------------------------------
  // link pins
  // ----------------------------------------------------------------------
  // incoming line is only ever sampled here, never driven
  assign link.tdm_bit_clock      = bclk_q;
  assign link.tdm_frame_sync_n   = sync_n_q;
  assign link.tdm_data_to_module = dout_q;

  // ----------------------------------------------------------------------
  // incoming data synchroniser
  // ----------------------------------------------------------------------
  // the module launches a few cycles after our rising edge, so the
  // value seen at the next rising edge is settled well past the sync
  logic din_s1_q;
  logic din_s2_q;
  logic din_s3_q;
  logic din_lvl_q;
  logic din_lvl_d;

  assign din_lvl_d = (din_s2_q == din_s3_q) ? din_s3_q : din_lvl_q;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      din_s1_q  <= 1'h0;
      din_s2_q  <= 1'h0;
      din_s3_q  <= 1'h0;
      din_lvl_q <= 1'h0;
    end
    else
    begin
      din_s1_q  <= link.tdm_data_from_module;
      din_s2_q  <= din_s1_q;
      din_s3_q  <= din_s2_q;
      din_lvl_q <= din_lvl_d;
    end
  end

  // ----------------------------------------------------------------------
  // status capture
  // ----------------------------------------------------------------------
  // each bit is taken at the rising edge that closes its slot and then
  // held for the whole frame, so controllers see a steady level
  logic [`TDM_RX_USED-1:0] rx_q;

  generate
    for (g = 0; g < `TDM_RX_USED; g++)
    begin : g_rx
      always_ff @(posedge clk)
      begin
        if (srst)
          rx_q[g] <= 1'h0;
        else if (rise_evt && slot_q == slot_t'(g))
          rx_q[g] <= din_lvl_q;
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------------
  // straight wires to the controllers; no register is mapped
  assign port3_cts                     = rx_q[`SLOT_P3_CTS];
  assign port3_set_ready_or_ident_bit1 = rx_q[`SLOT_P3_DSR_ID1];
  assign port3_dcd                     = rx_q[`SLOT_P3_DCD];
  assign port3_test_mode_or_ident_bit0 = rx_q[`SLOT_P3_TM_ID0];
  assign port3_ring                    = rx_q[`SLOT_P3_RI];
  assign port4_cts                     = rx_q[`SLOT_P4_CTS];
  assign port4_set_ready_or_ident_bit3 = rx_q[`SLOT_P4_DSR_ID3];
  assign port4_dcd                     = rx_q[`SLOT_P4_DCD];
  assign port4_test_mode_or_ident_bit2 = rx_q[`SLOT_P4_TM_ID2];
  assign port4_ring                    = rx_q[`SLOT_P4_RI];

endmodule

// File: common/tdm_map.svh
// offsets, slot positions, reset values and timing counts of the tdm link
`ifndef TDM_MAP_SVH
`define TDM_MAP_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define TDM_SYS_CLK_HZ      200000000
`define TDM_BIT_RATE_HZ     10000000
`define TDM_HALF_CYCLES     ((`TDM_SYS_CLK_HZ / `TDM_BIT_RATE_HZ) / 2)
`define TDM_DIV_W           8

// ----------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------
`define TDM_SLOT_W          4
`define TDM_SLOTS           16
`define TDM_SLOT_LAST       4'hF
`define TDM_SLOT_RESET      4'hF
`define TDM_TX_USED         9
`define TDM_RX_USED         10

// ----------------------------------------------------------------------
// outgoing slots (board to module)
// ----------------------------------------------------------------------
`define SLOT_P3_RTS         0
`define SLOT_P3_DTR         1
`define SLOT_P3_LLB_MODSEL  2
`define SLOT_P3_RLB         3
`define SLOT_P4_RTS         4
`define SLOT_P4_DTR         5
`define SLOT_P4_LLB         6
`define SLOT_P4_RLB         7
`define SLOT_IDENT_REQ      8

// ----------------------------------------------------------------------
// incoming slots (module to board)
// ----------------------------------------------------------------------
`define SLOT_P3_CTS         0
`define SLOT_P3_DSR_ID1     1
`define SLOT_P3_DCD         2
`define SLOT_P3_TM_ID0      3
`define SLOT_P3_RI          4
`define SLOT_P4_CTS         5
`define SLOT_P4_DSR_ID3     6
`define SLOT_P4_DCD         7
`define SLOT_P4_TM_ID2      8
`define SLOT_P4_RI          9

// ----------------------------------------------------------------------
// reset and idle levels
// ----------------------------------------------------------------------
`define TDM_SYNC_IDLE       1'h1
`define TDM_DATA_IDLE       1'h0
`define TDM_RESERVED_LEVEL  1'h0

`endif

// File: common/tdm_pkg.sv
// types shared by both ends of the tdm link
package tdm_pkg;

  typedef logic [3:0] slot_t;

  typedef enum logic [1:0] {
    ALIGN_HUNT   = 2'b01,
    ALIGN_LOCKED = 2'b10
  } align_state_t;

endpackage

// File: common/tdm_link_if.sv
// four-wire tdm link between main board and transition module
interface tdm_link_if;
  logic tdm_bit_clock;
  logic tdm_frame_sync_n;
  logic tdm_data_to_module;
  logic tdm_data_from_module;

  modport board (
    output tdm_bit_clock,
    output tdm_frame_sync_n,
    output tdm_data_to_module,
    input  tdm_data_from_module
  );

  modport module_end (
    input  tdm_bit_clock,
    input  tdm_frame_sync_n,
    input  tdm_data_to_module,
    output tdm_data_from_module
  );
endinterface

// File: core/module_mux_end.sv
// transition-module end of the modem-control line multiplexer
`include "tdm_map.svh"

module module_mux_end
  import tdm_pkg::*;
(
  // system
  input  wire logic      clk,
  input  wire logic      srst,
  // link
  tdm_link_if.module_end link,
  // status from the serial line drivers
  input  wire logic      port3_cts,
  input  wire logic      port3_set_ready_or_ident_bit1,
  input  wire logic      port3_dcd,
  input  wire logic      port3_test_mode_or_ident_bit0,
  input  wire logic      port3_ring,
  input  wire logic      port4_cts,
  input  wire logic      port4_set_ready_or_ident_bit3,
  input  wire logic      port4_dcd,
  input  wire logic      port4_test_mode_or_ident_bit2,
  input  wire logic      port4_ring,
  // controls toward the serial line drivers
  output logic           port3_rts,
  output logic           port3_dtr,
  output logic           port3_local_loop_or_module_select,
  output logic           port3_remote_loop,
  output logic           port4_rts,
  output logic           port4_dtr,
  output logic           port4_local_loop,
  output logic           port4_remote_loop,
  output logic           module_ident_request
);

  // ----------------------------------------------------------------------
  // pin synchronisers: bit 0 clock, bit 1 sync, bit 2 data
  // ----------------------------------------------------------------------
  logic [2:0]             pin_raw;
  logic [2:0]             s1_q;
  logic [2:0]             s2_q;
  logic [2:0]             s3_q;
  logic [2:0]             lvl_q;
  logic [2:0]             lvl_d;
  // reset to each pin's idle level so no false edge follows reset
  localparam logic [2:0] PIN_IDLE = {`TDM_DATA_IDLE, `TDM_SYNC_IDLE, 1'h0};

  assign pin_raw = {link.tdm_data_to_module, link.tdm_frame_sync_n,
                    link.tdm_bit_clock};

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_pin
      // a change counts only once stages two and three agree
      assign lvl_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : lvl_q[g];
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          s1_q[g]  <= PIN_IDLE[g];
          s2_q[g]  <= PIN_IDLE[g];
          s3_q[g]  <= PIN_IDLE[g];
          lvl_q[g] <= PIN_IDLE[g];
        end
        else
        begin
          s1_q[g]  <= pin_raw[g];
          s2_q[g]  <= s1_q[g];
          s3_q[g]  <= s2_q[g];
          lvl_q[g] <= lvl_d[g];
        end
      end
    end
  endgenerate

  wire rise_evt = lvl_d[0] & ~lvl_q[0];
  wire fall_evt = ~lvl_d[0] & lvl_q[0];
  wire sync_seen = ~lvl_q[1];

  // ----------------------------------------------------------------------
  // slot alignment
  // ----------------------------------------------------------------------
  slot_t        slot_q;
  slot_t        slot_d;
  align_state_t state_q;
  align_state_t state_d;
  logic [`TDM_SLOTS-1:0] tx_slots;
  logic         dout_q;
  logic         dout_d;

  // slot after the sync pulse is slot 0
  assign slot_d  = sync_seen ? slot_t'(0) : slot_t'(slot_q + 4'h1);
  assign state_d = sync_seen ? ALIGN_LOCKED : state_q;

  assign tx_slots = {6'h00, port4_ring, port4_test_mode_or_ident_bit2,
                     port4_dcd, port4_set_ready_or_ident_bit3, port4_cts,
                     port3_ring, port3_test_mode_or_ident_bit0, port3_dcd,
                     port3_set_ready_or_ident_bit1, port3_cts};
  // nothing is sent until aligned, so the board never sees a skewed frame
  assign dout_d = (state_d == ALIGN_LOCKED) ? tx_slots[slot_d]
                                            : `TDM_DATA_IDLE;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      slot_q  <= `TDM_SLOT_RESET;
      state_q <= ALIGN_HUNT;
      dout_q  <= `TDM_DATA_IDLE;
    end
    else if (rise_evt)
    begin
      slot_q  <= slot_d;
      state_q <= state_d;
      dout_q  <= dout_d;
    end
  end

  assign link.tdm_data_from_module = dout_q;

  // ----------------------------------------------------------------------
  // control capture at mid-bit, held between frames
  // ----------------------------------------------------------------------
  logic [`TDM_TX_USED-1:0] ctl_q;

  generate
    for (g = 0; g < `TDM_TX_USED; g++)
    begin : g_ctl
      always_ff @(posedge clk)
      begin
        if (srst)
          ctl_q[g] <= 1'h0;
        else if (fall_evt && state_q == ALIGN_LOCKED && slot_q == slot_t'(g))
          ctl_q[g] <= lvl_q[2];
      end
    end
  endgenerate

  assign port3_rts                         = ctl_q[`SLOT_P3_RTS];
  assign port3_dtr                         = ctl_q[`SLOT_P3_DTR];
  assign port3_local_loop_or_module_select = ctl_q[`SLOT_P3_LLB_MODSEL];
  assign port3_remote_loop                 = ctl_q[`SLOT_P3_RLB];
  assign port4_rts                         = ctl_q[`SLOT_P4_RTS];
  assign port4_dtr                         = ctl_q[`SLOT_P4_DTR];
  assign port4_local_loop                  = ctl_q[`SLOT_P4_LLB];
  assign port4_remote_loop                 = ctl_q[`SLOT_P4_RLB];
  assign module_ident_request              = ctl_q[`SLOT_IDENT_REQ];

endmodule

// File: tb/tdm_link_sva.sv
// concurrent checks on the four wires of the tdm link
module tdm_link_sva
#(
  parameter int unsigned HALF_CYCLES = 10
)
(
  // system
  input wire logic clk,
  input wire logic srst,
  // link wires
  input wire logic tdm_bit_clock,
  input wire logic tdm_frame_sync_n,
  input wire logic tdm_data_to_module,
  input wire logic tdm_data_from_module
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // ------------------------------------------------------------------
  // helper: slot and edge ages rebuilt from the wires alone
  // ------------------------------------------------------------------
  logic        clk_q;
  logic        sync_q;
  logic        seen_q;
  logic        sseen_q;
  logic [3:0]  slot_q;
  logic [15:0] age_q;
  logic [15:0] sage_q;
  wire         bc_edge  = tdm_bit_clock != clk_q;
  wire         sy_edge  = tdm_frame_sync_n != sync_q;
  wire  [3:0]  slot_now = (bc_edge && tdm_bit_clock) ? slot_q + 4'h1 : slot_q;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      {clk_q, sync_q, seen_q, sseen_q} <= 4'h4;
      slot_q <= 4'hF;
      age_q  <= 16'h0;
      sage_q <= 16'h0;
    end
    else
    begin
      {clk_q, sync_q} <= {tdm_bit_clock, tdm_frame_sync_n};
      seen_q  <= seen_q | bc_edge;
      sseen_q <= sseen_q | (sy_edge & tdm_frame_sync_n);
      slot_q  <= slot_now;
      age_q   <= bc_edge ? 16'h0 : age_q + 16'h1;
      sage_q  <= sy_edge ? 16'h0 : sage_q + 16'h1;
    end
  end

  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  clk_period_a: assert property (
    bc_edge && seen_q |-> age_q == HALF_CYCLES - 1)
    else $error("bit clock half period wrong");
  clk_alive_a: assert property (
    seen_q |-> age_q < HALF_CYCLES)
    else $error("bit clock stalled");
  sync_width_a: assert property (
    sy_edge && tdm_frame_sync_n |-> sage_q == 2 * HALF_CYCLES - 1)
    else $error("sync pulse not one bit long");
  frame_len_a: assert property (
    sy_edge && !tdm_frame_sync_n && sseen_q
    |-> sage_q == 30 * HALF_CYCLES - 1)
    else $error("frame not sixteen slots");
  sync_slot_a: assert property (
    bc_edge && !tdm_bit_clock |-> tdm_frame_sync_n == (slot_q != 4'hF))
    else $error("sync outside last slot");
  sync_fall_a: assert property (
    $changed(tdm_frame_sync_n) |-> bc_edge && !tdm_bit_clock)
    else $error("sync moved off the falling edge");
  data_rise_a: assert property (
    $changed(tdm_data_to_module) |-> bc_edge && tdm_bit_clock)
    else $error("outgoing data moved off the rising edge");
  reserved_out_a: assert property (
    slot_now > 4'h8 |-> !tdm_data_to_module)
    else $error("reserved outgoing slot not low");
  launch_a: assert property (
    $changed(tdm_data_from_module)
    |-> tdm_bit_clock && $past(tdm_bit_clock, 2))
    else $error("incoming data not launched after rise");
  reset_idle_a: assert property (
    $fell(srst) |-> !tdm_bit_clock && tdm_frame_sync_n
    && !tdm_data_to_module && !tdm_data_from_module)
    else $error("link not idle after reset");
endmodule

// File: tb/tb_modem_line_tdm_mux.sv
// self-checking bench: board end and module end joined by the tdm link
module tb_modem_line_tdm_mux;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------------
  // stimulus, observation and bookkeeping
  // ------------------------------------------------------------------
  localparam int HALF  = 10;
  localparam int FRAME = 32 * HALF;
  logic        clk         = 1'h0;
  logic        srst        = 1'h1;
  logic [8:0]  ctrl        = 9'h000;
  logic [9:0]  stat        = 10'h000;
  wire  [8:0]  ctrl_out;
  wire  [9:0]  stat_out;
  wire  [15:0] out_vec     = {7'h00, ctrl};
  wire  [15:0] in_vec      = {6'h00, stat};
  logic [18:0] notes[$];
  logic        go_q        = 1'h0;
  logic        wire_en     = 1'h0;
  logic        prev_bc     = 1'h0;
  logic        locked      = 1'h0;
  logic [3:0]  tslot       = 4'h0;
  logic [31:0] rnd;
  integer      seed        = 92100;
  int          n_fail      = 0;
  int          checks_done = 0;

  tdm_link_if link ();

  always #2.5 clk = ~clk;

  board_mux_end #(.HALF_CYCLES(HALF)) board_mux_end_inst (
    .clk(clk), .srst(srst), .link(link),
    .port3_rts(ctrl[0]), .port3_dtr(ctrl[1]),
    .port3_local_loop_or_module_select(ctrl[2]),
    .port3_remote_loop(ctrl[3]), .port4_rts(ctrl[4]),
    .port4_dtr(ctrl[5]), .port4_local_loop(ctrl[6]),
    .port4_remote_loop(ctrl[7]), .module_ident_request(ctrl[8]),
    .port3_cts(stat_out[0]), .port3_set_ready_or_ident_bit1(stat_out[1]),
    .port3_dcd(stat_out[2]), .port3_test_mode_or_ident_bit0(stat_out[3]),
    .port3_ring(stat_out[4]), .port4_cts(stat_out[5]),
    .port4_set_ready_or_ident_bit3(stat_out[6]), .port4_dcd(stat_out[7]),
    .port4_test_mode_or_ident_bit2(stat_out[8]), .port4_ring(stat_out[9])
  );

  module_mux_end module_mux_end_inst (
    .clk(clk), .srst(srst), .link(link),
    .port3_cts(stat[0]), .port3_set_ready_or_ident_bit1(stat[1]),
    .port3_dcd(stat[2]), .port3_test_mode_or_ident_bit0(stat[3]),
    .port3_ring(stat[4]), .port4_cts(stat[5]),
    .port4_set_ready_or_ident_bit3(stat[6]), .port4_dcd(stat[7]),
    .port4_test_mode_or_ident_bit2(stat[8]), .port4_ring(stat[9]),
    .port3_rts(ctrl_out[0]), .port3_dtr(ctrl_out[1]),
    .port3_local_loop_or_module_select(ctrl_out[2]),
    .port3_remote_loop(ctrl_out[3]), .port4_rts(ctrl_out[4]),
    .port4_dtr(ctrl_out[5]), .port4_local_loop(ctrl_out[6]),
    .port4_remote_loop(ctrl_out[7]), .module_ident_request(ctrl_out[8])
  );

  tdm_link_sva #(.HALF_CYCLES(HALF)) tdm_link_sva_inst (
    .clk(clk), .srst(srst),
    .tdm_bit_clock(link.tdm_bit_clock),
    .tdm_frame_sync_n(link.tdm_frame_sync_n),
    .tdm_data_to_module(link.tdm_data_to_module),
    .tdm_data_from_module(link.tdm_data_from_module)
  );

  // ------------------------------------------------------------------
  // comparison and closing report
  // ------------------------------------------------------------------
  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // wire monitor: slot found from sync, bits read mid-slot
  // ------------------------------------------------------------------
  always @(posedge clk)
  begin
    prev_bc <= link.tdm_bit_clock;
    if (srst)
      locked <= 1'h0;
    else if (prev_bc && !link.tdm_bit_clock)
    begin
      tslot = link.tdm_frame_sync_n ? tslot + 4'h1 : 4'hF;
      if (!link.tdm_frame_sync_n)
        locked <= 1'h1;
      if (!locked)
        check(link.tdm_data_from_module, 1'h0);
      if (wire_en)
      begin
        check(link.tdm_data_to_module, out_vec[tslot]);
        check(link.tdm_data_from_module, in_vec[tslot]);
      end
    end
  end

  // ------------------------------------------------------------------
  // output watcher: oldest note against both ends' user outputs
  // ------------------------------------------------------------------
  initial
  begin
    logic [18:0] exp;
    forever
    begin
      @(posedge clk);
      if (go_q && notes.size() > 0)
      begin
        exp = notes.pop_front();
        check({stat_out, ctrl_out}, exp);
      end
    end
  end

  // ------------------------------------------------------------------
  // driver
  // ------------------------------------------------------------------
  task automatic note_now(input logic [18:0] exp);
    notes.push_back(exp);
    go_q <= 1'h1;
    @(posedge clk);
    go_q <= 1'h0;
  endtask

  // outputs must read all zero straight after any reset
  task automatic do_reset();
    srst <= 1'h1;
    repeat (4) @(posedge clk);
    srst <= 1'h0;
    note_now(19'h00000);
  endtask

  // two frames to settle a change end to end, then one checked frame
  task automatic round(input logic [8:0] c, input logic [9:0] s);
    @(posedge clk);
    ctrl <= c;
    stat <= s;
    repeat (2 * FRAME) @(posedge clk);
    wire_en <= 1'h1;
    repeat (FRAME) @(posedge clk);
    wire_en <= 1'h0;
    note_now({s, c});
  endtask

  initial
  begin
    do_reset();
    repeat (FRAME) @(posedge clk);
    round(9'h000, 10'h000);
    round(9'h1FF, 10'h3FF);
    round(9'h155, 10'h2AA);
    round(9'h0AA, 10'h155);
    repeat (5)
    begin
      rnd = $random(seed);
      round(rnd[8:0], rnd[18:9]);
    end
    // reset in mid-frame with live inputs, then relock
    repeat (97) @(posedge clk);
    do_reset();
    repeat (FRAME) @(posedge clk);
    rnd = $random(seed);
    round(rnd[8:0], rnd[18:9]);
    // let the watcher take the last note before closing
    repeat (2) @(posedge clk);
    if (notes.size() != 0)
      n_fail++;
    results();
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    n_fail++;
    results();
  end
endmodule
